// *** rtl/pmsu_regs.vh ***
// Constants of the management port and startup block.
// Assumes inclusion by plain Verilog-2005 design files only.
`ifndef PMSU_REGS_VH
`define PMSU_REGS_VH
`define PMSU_NPORT 8
`define PMSU_PHY_ADDR 5'h00
`define PMSU_PRE_BITS 6'h20
`define PMSU_OP_WRITE 2'h1
`define PMSU_OP_READ 2'h2
`define PMSU_RA_CTRL 5'h00
`define PMSU_RA_STAT 5'h01
`define PMSU_RA_INT_EN 5'h12
`define PMSU_RA_INT_SET 5'h13
`define PMSU_RA_REFERENCE_CLOCK_OUTPUT 5'h14
`define PMSU_CTRL_RST 16'h3100
`define PMSU_INT_EN_RST 16'h0000
`define PMSU_REFERENCE_CLOCK_OUTPUT_RST 16'h0000
`define PMSU_REFERENCE_CLOCK_OUTPUT_EN_BIT 0
`define PMSU_REFERENCE_CLOCK_OUTPUT_SEL_BIT 1
`define PMSU_REFERENCE_CLOCK_OUTPUT_OVR_BIT 2
`define PMSU_CTRL_PDOWN_BIT 11
`define PMSU_EE_HALF 8'h7D
`define PMSU_EE_BITS 6'h24
`endif

// *** rtl/pmsu_sync.v ***
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ns
module pmsu_sync
(
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	// Pin and filtered level
	input wire pin_in,
	output reg level_reg
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge mclk)
	begin
		if (!rst_b)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_reg <= s3_reg;
		end
	end
endmodule // pmsu_sync

// *** rtl/pmsu_top.v ***
// Management port, interrupt pins, EEPROM startup and clock output.
// Assumes mdc, mdio, eeprom and device reset pins are asynchronous to mclk.
`timescale 1ns/1ns
`include "pmsu_regs.vh"
module pmsu_top
(
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	input wire device_reset_low,
	// Station management port
	input wire mdc,
	input wire mdio_in,
	output reg mdio_out,
	output reg mdio_oe,
	// Port interrupts
	input wire [`PMSU_NPORT-1:0] port_event,
	input wire [`PMSU_NPORT-1:0] int_polarity_strap,
	output reg [`PMSU_NPORT-1:0] port_mgmt_interrupt_out,
	output reg [`PMSU_NPORT-1:0] port_mgmt_interrupt_oe,
	// EEPROM
	input wire eeprom_serial_data_in,
	output reg eeprom_serial_data_out,
	output reg eeprom_serial_data_oe,
	output reg eeprom_serial_clock,
	output reg eeprom_present,
	// Clock output control
	input wire config_strap_select,
	input wire clk_125,
	input wire clk_156,
	output wire reference_clock_output,
	output reg power_down
);
	localparam ST_IDLE = 3'h0;
	localparam ST_OPC = 3'h1;
	localparam ST_ADDR = 3'h2;
	localparam ST_TA = 3'h3;
	localparam ST_DATA = 3'h4;
	wire mdc_s;
	wire mdio_s;
	wire rstpin_s;
	wire ee_s;
	reg mdc_d_reg;
	reg [2:0] st_reg;
	reg [5:0] cnt_reg;
	reg [3:0] opst_reg;
	reg [9:0] addr_reg;
	reg [15:0] sh_reg;
	reg rd_reg;
	reg [15:0] ctrl_reg;
	reg [15:0] int_en_reg;
	reg [15:0] reference_clock_output_reg;
	reg [`PMSU_NPORT-1:0] pend_reg;
	reg [`PMSU_NPORT-1:0] pol_reg;
	reg rstpin_d_reg;
	reg strap_reg;
	reg [7:0] ee_div_reg;
	reg [5:0] ee_bits_reg;
	reg ee_run_reg;
	reg [15:0] rdata;
	wire mdc_rise;
	wire in_rst;
	wire ck_en;
	wire ck_sel;
	pmsu_sync u_mdc (.mclk(mclk), .rst_b(rst_b), .pin_in(mdc), .level_reg(mdc_s));
	pmsu_sync u_mdio (.mclk(mclk), .rst_b(rst_b), .pin_in(mdio_in), .level_reg(mdio_s));
	pmsu_sync u_rst (.mclk(mclk), .rst_b(rst_b), .pin_in(device_reset_low),
		.level_reg(rstpin_s));
	pmsu_sync u_ee (.mclk(mclk), .rst_b(rst_b), .pin_in(eeprom_serial_data_in),
		.level_reg(ee_s));
	assign mdc_rise = mdc_s & ~mdc_d_reg;
	assign in_rst = ~rstpin_s;
	function is_addr;
		input [9:0] a;
		input [4:0] ra;
		begin
			is_addr = (a[9:5] == `PMSU_PHY_ADDR) && (a[4:0] == ra);
		end
	endfunction
	always @*
	begin
		rdata = 16'h0000;
		if (addr_reg[4:0] == `PMSU_RA_CTRL)
			rdata = ctrl_reg;
		else if (addr_reg[4:0] == `PMSU_RA_STAT)
			rdata = {15'h0000, eeprom_present};
		else if (addr_reg[4:0] == `PMSU_RA_INT_EN)
			rdata = int_en_reg;
		else if (addr_reg[4:0] == `PMSU_RA_INT_SET)
			rdata = {8'h00, pend_reg};
		else if (addr_reg[4:0] == `PMSU_RA_REFERENCE_CLOCK_OUTPUT)
			rdata = reference_clock_output_reg;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Management frame engine
	always @(posedge mclk)
	begin
		if (!rst_b || in_rst)
		begin
			mdc_d_reg <= 1'b0;
			st_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
			opst_reg <= 4'h0;
			addr_reg <= 10'h000;
			sh_reg <= 16'h0000;
			rd_reg <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			ctrl_reg <= `PMSU_CTRL_RST;
			int_en_reg <= `PMSU_INT_EN_RST;
			reference_clock_output_reg <= `PMSU_REFERENCE_CLOCK_OUTPUT_RST;
			pend_reg <= {`PMSU_NPORT{1'b0}};
		end
		else
		begin
			mdc_d_reg <= mdc_s;
			pend_reg <= pend_reg | port_event;
			if (mdc_rise)
			begin
				case (st_reg)
					ST_IDLE:
					begin
						mdio_oe <= 1'b0;
						if (mdio_s)
							cnt_reg <= (cnt_reg == `PMSU_PRE_BITS) ? cnt_reg : cnt_reg + 6'h01;
						else
						begin
							if (cnt_reg == `PMSU_PRE_BITS)
								st_reg <= ST_OPC;
							cnt_reg <= 6'h00;
						end
					end
					ST_OPC:
					begin
						opst_reg <= {opst_reg[2:0], mdio_s};
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg == 6'h02)
						begin
							cnt_reg <= 6'h00;
							st_reg <= ({opst_reg[1:0], mdio_s} == {1'b1, `PMSU_OP_WRITE} ||
								{opst_reg[1:0], mdio_s} == {1'b1, `PMSU_OP_READ}) ?
								ST_ADDR : ST_IDLE;
						end
					end
					ST_ADDR:
					begin
						addr_reg <= {addr_reg[8:0], mdio_s};
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg == 6'h09)
						begin
							cnt_reg <= 6'h00;
							st_reg <= ST_TA;
							rd_reg <= (opst_reg[1:0] == `PMSU_OP_READ);
						end
					end
					ST_TA:
					begin
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg == 6'h00 && rd_reg && addr_reg[9:5] == `PMSU_PHY_ADDR)
						begin
							sh_reg <= rdata;
							mdio_out <= 1'b0;
							mdio_oe <= 1'b1;
						end
						if (cnt_reg == 6'h01)
						begin
							cnt_reg <= 6'h00;
							st_reg <= ST_DATA;
							if (mdio_oe)
							begin
								mdio_oe <= ~sh_reg[15];
								sh_reg <= {sh_reg[14:0], 1'b0};
							end
						end
					end
					default:
					begin
						cnt_reg <= cnt_reg + 6'h01;
						if (rd_reg)
						begin
							mdio_oe <= (addr_reg[9:5] == `PMSU_PHY_ADDR) & ~sh_reg[15] & (cnt_reg != 6'h0F);
							sh_reg <= {sh_reg[14:0], 1'b0};
						end
						else
							sh_reg <= {sh_reg[14:0], mdio_s};
						if (cnt_reg == 6'h0F)
						begin
							cnt_reg <= 6'h00;
							st_reg <= ST_IDLE;
							mdio_oe <= 1'b0;
							if (!rd_reg && is_addr(addr_reg, `PMSU_RA_CTRL))
								ctrl_reg <= {sh_reg[14:0], mdio_s};
							if (!rd_reg && is_addr(addr_reg, `PMSU_RA_INT_EN))
								int_en_reg <= {sh_reg[14:0], mdio_s};
							if (!rd_reg && is_addr(addr_reg, `PMSU_RA_REFERENCE_CLOCK_OUTPUT))
								reference_clock_output_reg <= {sh_reg[14:0], mdio_s};
							if (rd_reg && is_addr(addr_reg, `PMSU_RA_INT_SET))
								pend_reg <= port_event; // read clears, new event wins
						end
					end
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pins, power down
	always @(posedge mclk)
	begin
		if (!rst_b)
		begin
			port_mgmt_interrupt_out <= {`PMSU_NPORT{1'b0}};
			port_mgmt_interrupt_oe <= {`PMSU_NPORT{1'b0}};
			power_down <= 1'b1;
		end
		else
		begin
			power_down <= in_rst | ctrl_reg[`PMSU_CTRL_PDOWN_BIT];
			port_mgmt_interrupt_out <= pol_reg;
			port_mgmt_interrupt_oe <= pend_reg & int_en_reg[`PMSU_NPORT-1:0] &
				{`PMSU_NPORT{~in_rst}};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Strap capture at reset release, EEPROM load clock
	always @(posedge mclk)
	begin
		if (!rst_b)
		begin
			rstpin_d_reg <= 1'b0;
			pol_reg <= {`PMSU_NPORT{1'b0}};
			strap_reg <= 1'b0;
			eeprom_present <= 1'b0;
			ee_run_reg <= 1'b0;
			ee_div_reg <= 8'h00;
			ee_bits_reg <= 6'h00;
			eeprom_serial_clock <= 1'b0;
			eeprom_serial_data_out <= 1'b0;
			eeprom_serial_data_oe <= 1'b0;
		end
		else
		begin
			rstpin_d_reg <= rstpin_s;
			if (rstpin_s && !rstpin_d_reg)
			begin
				pol_reg <= int_polarity_strap;
				strap_reg <= config_strap_select;
				eeprom_present <= ee_s;
				ee_run_reg <= ee_s;
				ee_bits_reg <= 6'h00;
			end
			else if (ee_run_reg && !in_rst)
			begin
				ee_div_reg <= ee_div_reg + 8'h01;
				if (ee_div_reg == `PMSU_EE_HALF)
				begin
					ee_div_reg <= 8'h00;
					eeprom_serial_clock <= ~eeprom_serial_clock;
					if (eeprom_serial_clock)
					begin
						ee_bits_reg <= ee_bits_reg + 6'h01;
						eeprom_serial_data_oe <= (ee_bits_reg < 6'h09) & ~ee_bits_reg[0];
						if (ee_bits_reg == `PMSU_EE_BITS)
							ee_run_reg <= 1'b0;
					end
				end
			end
			else
			begin
				eeprom_serial_clock <= 1'b0;
				eeprom_serial_data_oe <= 1'b0;
			end
		end
	end
	assign ck_sel = reference_clock_output_reg[`PMSU_REFERENCE_CLOCK_OUTPUT_OVR_BIT] ? reference_clock_output_reg[`PMSU_REFERENCE_CLOCK_OUTPUT_SEL_BIT] : strap_reg;
	assign ck_en = reference_clock_output_reg[`PMSU_REFERENCE_CLOCK_OUTPUT_EN_BIT] & ~in_rst & rst_b;
	assign reference_clock_output = ck_en & (ck_sel ? clk_156 : clk_125);
endmodule // pmsu_top

// *** tb/pmsu_monitor.sv ***
// Pin checker for the management port and startup block.
// Assumes strap pins are steady and rst_b is the bench reset.
`timescale 1ns/1ns
module pmsu_monitor
(
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	input wire device_reset_low,
	// Observed pins
	input wire mdio_out,
	input wire mdio_oe,
	input wire [7:0] int_polarity_strap,
	input wire [7:0] port_mgmt_interrupt_out,
	input wire [7:0] port_mgmt_interrupt_oe,
	input wire eeprom_serial_data_out,
	input wire eeprom_serial_data_oe,
	input wire eeprom_serial_clock,
	input wire eeprom_present,
	input wire reference_clock_output,
	input wire power_down
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////
	sequence s_rst_held; !device_reset_low [*8]; endsequence
	property p_md; mdio_oe |-> !mdio_out; endproperty
	property p_ip; (port_mgmt_interrupt_oe & (port_mgmt_interrupt_out ^ int_polarity_strap)) == 0;
	endproperty
	property p_eo; eeprom_serial_data_oe |-> !eeprom_serial_data_out; endproperty
	property p_en; !eeprom_present |-> !eeprom_serial_clock && !eeprom_serial_data_oe; endproperty
	property p_et; $changed(eeprom_serial_clock) |=> $stable(eeprom_serial_clock) [*8]; endproperty
	property p_pd; s_rst_held |-> power_down; endproperty
	property p_rc; s_rst_held |-> !reference_clock_output; endproperty
	property p_rl; s_rst_held |-> port_mgmt_interrupt_oe == 0 && !mdio_oe; endproperty
	a_md: assert property (p_md) else $error("mdio driven high");
	a_ip: assert property (p_ip) else $error("interrupt level wrong");
	a_eo: assert property (p_eo) else $error("eeprom data driven high");
	a_en: assert property (p_en) else $error("eeprom pins active");
	a_et: assert property (p_et) else $error("eeprom clock too fast");
	a_pd: assert property (p_pd) else $error("not powered down");
	a_rc: assert property (p_rc) else $error("clock out active");
	a_rl: assert property (p_rl) else $error("pins not released");
endmodule // pmsu_monitor
bind pmsu_top pmsu_monitor u_pmsu_monitor (.mclk, .rst_b, .device_reset_low, .mdio_out,
	.mdio_oe, .int_polarity_strap, .port_mgmt_interrupt_out, .port_mgmt_interrupt_oe,
	.eeprom_serial_data_out, .eeprom_serial_data_oe, .eeprom_serial_clock, .eeprom_present,
	.reference_clock_output, .power_down);

// *** tb/pmsu_station.sv ***
// Station manager model sending frames over mdc and mdio.
// Assumes mdio has a pull-up and every party only pulls low.
`timescale 1ns/1ns
module pmsu_station
(
	// Management pins
	output reg mdc,
	output reg mdio_oe,
	input wire mdio
);
	integer hp;
	initial
	begin
		mdc = 1'b0;
		mdio_oe = 1'b0;
		hp = 62;
	end
	////////////////////////////////
	task frame(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] wd,
		output [15:0] rd);
		reg [63:0] f;
		integer i;
		begin
			f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
			for (i = 63; i >= 0; i = i - 1)
			begin
				mdio_oe = (op == 2'h2 && i < 18) ? 1'b0 : !f[i];
				#hp mdc = 1'b1;
				rd = {rd[14:0], mdio};
				#(hp + 1) mdc = 1'b0;
			end
			mdio_oe = 1'b0;
		end
	endtask
endmodule // pmsu_station

// *** tb/tb_top.sv ***
// Self-checking bench for the management port and startup block.
// Assumes the station model owns mdc and the bench models the mdio pull-up.
`timescale 1ns/1ns
module tb_top;
	reg mclk = 0, rst_b = 0, device_reset_low = 0, clk_125 = 0, clk_156 = 0, ee_pull = 0, strap = 0;
	reg [7:0] port_event = 0, m, e;
	reg [15:0] rd;
	wire mdc, st_oe, mdio_out, mdio_oe, ee_oe, ee_clk, ee_pres, rco, pd;
	wire [7:0] int_out, int_oe;
	wire mdio = !(st_oe | mdio_oe);
	integer failures = 0, checked = 0, seed = 32'h9ADE, i, j, n;
	always #5 mclk = !mclk;
	always #4 clk_125 = !clk_125;
	always #3 clk_156 = !clk_156;
	pmsu_top u_pmsu_top (.mclk(mclk), .rst_b(rst_b), .device_reset_low(device_reset_low),
		.mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.port_event(port_event), .int_polarity_strap(8'hA5),
		.port_mgmt_interrupt_out(int_out), .port_mgmt_interrupt_oe(int_oe),
		.eeprom_serial_data_in(ee_pull & !ee_oe), .eeprom_serial_data_out(),
		.eeprom_serial_data_oe(ee_oe), .eeprom_serial_clock(ee_clk), .eeprom_present(ee_pres),
		.config_strap_select(strap), .clk_125(clk_125), .clk_156(clk_156),
		.reference_clock_output(rco), .power_down(pd));
	pmsu_station u_pmsu_station (.mdc(mdc), .mdio_oe(st_oe), .mdio(mdio));
	////////////////////////////////
	task check(input string nm, input [15:0] got, input [15:0] want);
		begin
			checked = checked + 1;
			if (got !== want)
			begin
				failures = failures + 1;
				$display("BAD %s exp %h got %h", nm, want, got);
			end
		end
	endtask
	task xfer(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] d);
		begin
			u_pmsu_station.frame(op, phy, ra, d, rd);
			repeat (10) @(negedge mclk);
		end
	endtask
	task count_rco;
		reg last;
		begin
			n = 0;
			last = rco;
			repeat (120)
			begin
				#1;
				n = n + (rco !== last);
				last = rco;
			end
		end
	endtask
	function exp_sel(input [2:0] v, input s);
		exp_sel = v[2] ? v[1] : s;
	endfunction
	task finish_test;
		begin
			$display("checked %0d failures %0d", checked, failures);
			if (failures == 0 && checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial
	begin
		#900000;
		failures = failures + 1;
		finish_test;
	end
	initial
	begin
		repeat (3) @(negedge mclk);
		rst_b = 1;
		device_reset_low = 1;
		repeat (10) @(negedge mclk);
		check("ee_pres", ee_pres, 0);
		xfer(2'h2, 5'h00, 5'h00, 0);
		check("ctrl", rd, 16'h3100);
		$display("test reset done");
		for (i = 0; i < 8; i = i + 1)
		begin
			strap = i[0];
			device_reset_low = 0;
			repeat (8) @(negedge mclk);
			device_reset_low = 1;
			repeat (8) @(negedge mclk);
			xfer(2'h1, 5'h00, 5'h14, {i[2:1], 1'b1});
			count_rco;
			check("rco_sel", {n > 35, n > 20}, {exp_sel({i[2:1], 1'b1}, strap), 1'b1});
		end
		xfer(2'h1, 5'h01, 5'h14, 0);
		count_rco;
		check("rco_phy", n > 0, 1);
		xfer(2'h1, 5'h00, 5'h14, 0);
		count_rco;
		check("rco_off", n + rco, 0);
		$display("test refclk done");
		for (j = 0; j < 2; j = j + 1)
		begin
			m = j ? 8'hFF : $random(seed);
			e = j ? 8'hFF : $random(seed);
			xfer(2'h1, 5'h00, 5'h12, m);
			port_event = e;
			@(negedge mclk);
			port_event = 0;
			repeat (10) @(negedge mclk);
			check("int_oe", int_oe, m & e);
			xfer(2'h2, 5'h00, 5'h13, 0);
			check("int_clr", int_oe, 0);
			check("int_pend", rd, {8'h00, e});
		end
		$display("test interrupt done");
		xfer(2'h1, 5'h00, 5'h00, 16'h0800);
		check("pd_reg", pd, 1);
		ee_pull = 1;
		device_reset_low = 0;
		repeat (20) @(negedge mclk);
		check("pd_rst", {pd, int_oe, rco}, 10'h200);
		device_reset_low = 1;
		for (i = 0; i < 300 && ee_clk !== 1; i = i + 1)
			@(negedge mclk);
		check("ee_clk", {ee_pres, ee_clk}, 2'h3);
		repeat (10000) @(negedge mclk);
		check("ee_done", ee_clk, 0);
		xfer(2'h2, 5'h00, 5'h12, 0);
		check("int_en", rd, 0);
		check("pd_end", pd, 0);
		xfer(2'h2, 5'h00, 5'h01, 0);
		check("stat", rd, 16'h0001);
		$display("test device reset done");
		finish_test;
	end
endmodule // tb_top
